/* common/idw_pkg.sv */
// idw_pkg: constants and carrier types for the two-wire converter word slave.
// assumes: imported by every design file of the block.
package idw_pkg;
   // ==========================================================
   // address map
   localparam logic [6:0] IDW_ADDR_BROADCAST = 7'h48;
   localparam logic [6:0] IDW_ADDR_SINGLE_FLOAT = 7'h0C;
   localparam logic [6:0] IDW_ADDR_SINGLE_GND = 7'h0D;
   localparam logic [6:0] IDW_ADDR_SINGLE_SUPPLY = 7'h0E;
   localparam logic [6:0] IDW_BASE_HIGH_FLOAT = 7'h0C;
   localparam logic [6:0] IDW_BASE_HIGH_GND = 7'h08;
   localparam logic [6:0] IDW_BASE_HIGH_SUPPLY = 7'h4C;
   localparam logic [6:0] IDW_OFFSET_LOW_FLOAT = 7'h00;
   localparam logic [6:0] IDW_OFFSET_LOW_GND = 7'h01;
   localparam logic [6:0] IDW_OFFSET_LOW_SUPPLY = 7'h02;
   localparam logic [4:0] IDW_MASTER_CODE_TOP = 5'h01;
   // ==========================================================
   // register word layout and reset
   localparam logic [15:0] IDW_WORD_RESET = 16'h0000;
   localparam int IDW_MODE_MSB = 13;
   localparam int IDW_MODE_LSB = 12;
   localparam int IDW_CODE_MSB = 11;
   localparam int IDW_CODE_LSB = 2;
   localparam logic [1:0] IDW_MODE_NORMAL = 2'h0;
   localparam logic [1:0] IDW_MODE_PD_2K5 = 2'h1;
   localparam logic [1:0] IDW_MODE_PD_100K = 2'h2;
   localparam logic [1:0] IDW_MODE_PD_HIZ = 2'h3;
   localparam int IDW_SYNC_STAGES = 2;
   // ==========================================================
   // three-level select strap encoding
   typedef enum logic [1:0] {
      IDW_LVL_FLOAT = 2'h0,
      IDW_LVL_GND = 2'h1,
      IDW_LVL_SUPPLY = 2'h2
   } idw_level_t;
   // bus events found by the line sampler
   typedef struct packed {
      logic start;
      logic stop;
      logic scl_rise;
      logic scl_fall;
      logic sda;
   } idw_line_ev_t;
   // converter-facing outputs
   typedef struct packed {
      logic [9:0] code;
      logic powered_down;
      logic term_2k5;
      logic term_100k;
      logic term_hiz;
   } idw_conv_t;
endpackage

/* src/idw_addr_select.sv */
// idw_addr_select: turns strap levels into the selectable slave address.
// assumes: level inputs are already synchronised and held by the caller.
`timescale 1ns/1ns
module idw_addr_select
   import idw_pkg::*;
(
   // variant choice
   input wire logic two_pin_variant,
   // strap levels
   input idw_pkg::idw_level_t level_high,
   input idw_pkg::idw_level_t level_low,
   // result
   output logic [6:0] addr
);
   import idw_pkg::*;
   wire [6:0] single_addr =
      (level_low == IDW_LVL_GND) ? IDW_ADDR_SINGLE_GND :
      (level_low == IDW_LVL_SUPPLY) ? IDW_ADDR_SINGLE_SUPPLY : IDW_ADDR_SINGLE_FLOAT;
   wire [6:0] base =
      (level_high == IDW_LVL_GND) ? IDW_BASE_HIGH_GND :
      (level_high == IDW_LVL_SUPPLY) ? IDW_BASE_HIGH_SUPPLY : IDW_BASE_HIGH_FLOAT;
   wire [6:0] offset =
      (level_low == IDW_LVL_GND) ? IDW_OFFSET_LOW_GND :
      (level_low == IDW_LVL_SUPPLY) ? IDW_OFFSET_LOW_SUPPLY : IDW_OFFSET_LOW_FLOAT;
   wire [6:0] nine_addr = base | offset;
   assign addr = two_pin_variant ? nine_addr : single_addr;
endmodule

/* src/idw_line_sampler.sv */
// idw_line_sampler: synchronises scl/sda and finds edges and start/stop.
// assumes: clk_sys much faster than scl; pins asynchronous to clk_sys.
`timescale 1ns/1ns
module idw_line_sampler
   import idw_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   // events
   output idw_pkg::idw_line_ev_t ev
);
   import idw_pkg::*;
   logic [IDW_SYNC_STAGES-1:0] scl_sync;
   logic [IDW_SYNC_STAGES-1:0] sda_sync;
   logic scl_prev;
   logic sda_prev;
   wire scl_now = scl_sync[IDW_SYNC_STAGES-1];
   wire sda_now = sda_sync[IDW_SYNC_STAGES-1];

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         scl_sync <= '1;
         sda_sync <= '1;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[IDW_SYNC_STAGES-2:0], scl_in};
         sda_sync <= {sda_sync[IDW_SYNC_STAGES-2:0], sda_in};
         scl_prev <= scl_now;
         sda_prev <= sda_now;
      end
   end

   // start/stop only while scl stays high across the sda change
   assign ev.start = scl_now & scl_prev & sda_prev & ~sda_now;
   assign ev.stop = scl_now & scl_prev & ~sda_prev & sda_now;
   assign ev.scl_rise = scl_now & ~scl_prev;
   assign ev.scl_fall = ~scl_now & scl_prev;
   assign ev.sda = sda_now;
endmodule

/* src/idw_slave.sv */
// idw_slave: two-wire slave owning the 16-bit converter word.
// assumes: clk_sys at 100 MHz oversamples scl; sda is open drain with pull-up.
`timescale 1ns/1ns
module idw_slave
   import idw_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // variant and address straps
   input wire logic two_pin_variant,
   input idw_pkg::idw_level_t addr_select_high_pin,
   input idw_pkg::idw_level_t addr_select_low_pin,
   // two-wire bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // converter side
   output idw_pkg::idw_conv_t conv,
   output logic [15:0] converter_word,
   output logic hs_mode
);
   import idw_pkg::*;

   // ==========================================================
   // state machine
   typedef enum logic [6:0] {
      IDW_IDLE = 7'h01,
      IDW_ADDR = 7'h02,
      IDW_ADDR_ACK = 7'h04,
      IDW_WR_BYTE = 7'h08,
      IDW_WR_ACK = 7'h10,
      IDW_RD_BYTE = 7'h20,
      IDW_RD_ACK = 7'h40
   } idw_state_t;

   idw_state_t state;
   idw_state_t next_state;
   idw_line_ev_t ev;
   logic [7:0] shift;
   logic [2:0] bit_cnt;
   logic byte_low;
   logic [7:0] upper_hold;
   logic [6:0] locked_addr;
   logic addr_locked;
   logic [1:0] lvl_high_s1;
   logic [1:0] lvl_high_s2;
   logic [1:0] lvl_low_s1;
   logic [1:0] lvl_low_s2;
   logic [6:0] strap_addr;
   logic ack_drive;
   logic master_nack;
   logic read_dir;

   // ==========================================================
   // pin sampling
   idw_line_sampler u_line (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .ev(ev)
   );

   // straps are pins: two flops before decoding
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lvl_high_s1 <= 2'h0;
         lvl_high_s2 <= 2'h0;
         lvl_low_s1 <= 2'h0;
         lvl_low_s2 <= 2'h0;
      end else begin
         lvl_high_s1 <= addr_select_high_pin;
         lvl_high_s2 <= lvl_high_s1;
         lvl_low_s1 <= addr_select_low_pin;
         lvl_low_s2 <= lvl_low_s1;
      end
   end

   idw_addr_select u_sel (
      .two_pin_variant(two_pin_variant),
      .level_high(idw_level_t'(lvl_high_s2)),
      .level_low(idw_level_t'(lvl_low_s2)),
      .addr(strap_addr)
   );

   // ==========================================================
   // decode
   wire [7:0] rx_byte = {shift[6:0], ev.sda};
   wire byte_done = ev.scl_rise & (bit_cnt == 3'h7);
   // ack clock ends at the fall after the ninth rise, not the eighth fall
   wire ack_end = ev.scl_fall & (bit_cnt == 3'h1);
   wire [6:0] own_addr = addr_locked ? locked_addr : strap_addr;
   wire own_match = (rx_byte[7:1] == own_addr);
   wire bcast_match = (rx_byte[7:1] == IDW_ADDR_BROADCAST);
   wire master_code = (rx_byte[7:3] == IDW_MASTER_CODE_TOP);
   wire addr_hit = (own_match | bcast_match) & ~master_code;
   wire is_read = rx_byte[0];
   // lower byte sits whole in shift at the ack rise; sda then is only the ack
   wire [15:0] new_word = {2'b00, upper_hold[5:0], shift};
   wire ack_rise = ev.scl_rise & (state == IDW_WR_ACK) & byte_low;
   // in the master's ack byte_low has not toggled yet, but the other byte goes next
   wire [7:0] tx_byte = (byte_low ^ (state == IDW_RD_ACK)) ? converter_word[7:0]
      : converter_word[15:8];

   always_comb begin
      next_state = state;
      unique case (state)
         IDW_IDLE: next_state = IDW_IDLE;
         IDW_ADDR: begin
            if (byte_done) begin
               next_state = addr_hit ? IDW_ADDR_ACK : IDW_IDLE;
            end
         end
         IDW_ADDR_ACK: begin
            if (ack_end) begin
               next_state = read_dir ? IDW_RD_BYTE : IDW_WR_BYTE;
            end
         end
         IDW_WR_BYTE: begin
            if (byte_done) begin
               next_state = IDW_WR_ACK;
            end
         end
         IDW_WR_ACK: begin
            if (ack_end) begin
               next_state = IDW_WR_BYTE;
            end
         end
         IDW_RD_BYTE: begin
            if (ev.scl_fall & (bit_cnt == 3'h0) & ack_drive) begin
               next_state = IDW_RD_ACK;
            end
         end
         IDW_RD_ACK: begin
            if (ev.scl_fall) begin
               next_state = master_nack ? IDW_IDLE : IDW_RD_BYTE;
            end
         end
      endcase
      // start or repeated start always reopens address phase
      if (ev.start) begin
         next_state = IDW_ADDR;
      end
      if (ev.stop) begin
         next_state = IDW_IDLE;
      end
   end

   // ==========================================================
   // state, bit counting and shifting
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state <= IDW_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         shift <= 8'h00;
         bit_cnt <= 3'h0;
      end else begin
         // shift on every rise so the byte is whole even at a state change
         if (ev.scl_rise) begin
            shift <= rx_byte;
         end
         if (ev.start | (state != next_state)) begin
            bit_cnt <= 3'h0;
         end else if (ev.scl_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
         end
      end
   end

   // ack_drive marks that the read byte's eighth rise has passed, so sda is freed at its last fall
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ack_drive <= 1'b0;
         master_nack <= 1'b0;
      end else begin
         if (state != IDW_RD_BYTE) begin
            ack_drive <= 1'b0;
         end else if (ev.scl_rise & (bit_cnt == 3'h7)) begin
            ack_drive <= 1'b1;
         end
         if (ev.scl_rise & (state == IDW_RD_ACK)) begin
            master_nack <= ev.sda;
         end
      end
   end

   // byte_low toggles per data byte; resets at every address phase
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         byte_low <= 1'b0;
         upper_hold <= 8'h00;
         read_dir <= 1'b0;
      end else if (state == IDW_ADDR) begin
         byte_low <= 1'b0;
         if (byte_done) begin
            read_dir <= is_read;
         end
      end else begin
         if ((state == IDW_WR_BYTE) & byte_done & ~byte_low) begin
            upper_hold <= rx_byte;
         end
         if (((state == IDW_WR_ACK) | (state == IDW_RD_ACK)) & ack_end) begin
            byte_low <= ~byte_low;
         end
      end
   end

   // ==========================================================
   // address lock and high-speed tracking
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         addr_locked <= 1'b0;
         locked_addr <= 7'h00;
         hs_mode <= 1'b0;
      end else begin
         if ((state == IDW_ADDR) & byte_done & own_match & ~bcast_match
             & ~master_code & ~addr_locked) begin
            addr_locked <= 1'b1;
            locked_addr <= strap_addr;
         end
         if (ev.stop) begin
            hs_mode <= 1'b0;
         end else if ((state == IDW_ADDR) & byte_done & master_code) begin
            hs_mode <= 1'b1;
         end
      end
   end

   // ==========================================================
   // register word and converter outputs
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         converter_word <= IDW_WORD_RESET;
         conv <= '0;
      end else if (ack_rise) begin
         converter_word <= new_word;
         conv.code <= new_word[IDW_CODE_MSB:IDW_CODE_LSB];
         conv.powered_down <= |new_word[IDW_MODE_MSB:IDW_MODE_LSB];
         conv.term_2k5 <= new_word[IDW_MODE_MSB:IDW_MODE_LSB] == IDW_MODE_PD_2K5;
         conv.term_100k <= new_word[IDW_MODE_MSB:IDW_MODE_LSB] == IDW_MODE_PD_100K;
         conv.term_hiz <= new_word[IDW_MODE_MSB:IDW_MODE_LSB] == IDW_MODE_PD_HIZ;
      end
   end

   // ==========================================================
   // sda driver: changes after scl falls, or releases at start/stop, so data is stable while high
   wire drive_ack = (next_state == IDW_ADDR_ACK) | (next_state == IDW_WR_ACK);
   // first bit of a byte leaves while bit_cnt still counts the ack clock
   wire [2:0] tx_idx = (state == IDW_RD_BYTE) ? 3'h7 - bit_cnt : 3'h7;
   wire drive_rd = (next_state == IDW_RD_BYTE) & ~ack_drive & ~tx_byte[tx_idx];

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
      end else if (ev.scl_fall | ev.stop | ev.start) begin
         sda_oe <= (drive_ack | drive_rd) & ~ev.stop & ~ev.start;
         sda_out <= 1'b0;
      end
   end
endmodule

/* test/idw_bus_master.sv */
// behavioural two-wire master; bit period 160 ns.
// assumes: callers start each frame 1 ns after a clk_sys rise; sda resolved outside.
`timescale 1ns/1ns
module idw_bus_master (
   // bus lines
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // ==========================================================
   // conditions and bits
   task automatic start_cond();
      sda_low = 1'b0;
      #40 scl = 1'b1;
      #40 sda_low = 1'b1;
      #40 scl = 1'b0;
      #40;
   endtask
   task automatic stop_cond();
      sda_low = 1'b1;
      #40 scl = 1'b1;
      #40 sda_low = 1'b0;
      #80;
   endtask
   task automatic put_bit(input logic b);
      sda_low = !b;
      #40 scl = 1'b1;
      #80 scl = 1'b0;
      #40;
   endtask
   // released line: the slave or the pull-up decides
   task automatic get_bit(output logic b);
      sda_low = 1'b0;
      #40 scl = 1'b1;
      #40 b = sda;
      #40 scl = 1'b0;
      #40;
   endtask
   // ==========================================================
   // bytes
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(b);
      ack = !b;
   endtask
   task automatic rd_byte(output logic [7:0] d, input logic more);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(!more);
   endtask
endmodule

/* test/idw_slave_assertions.sv */
// concurrent checks on the converter word slave ports.
// assumes: bound into every idw_slave; bus pins sampled raw on clk_sys.
`timescale 1ns/1ns
module idw_slave_checker
   import idw_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // straps and bus
   input wire logic two_pin_variant,
   input idw_pkg::idw_level_t addr_select_high_pin,
   input idw_pkg::idw_level_t addr_select_low_pin,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // converter side
   input idw_pkg::idw_conv_t conv,
   input wire logic [15:0] converter_word,
   input wire logic hs_mode
);
   default clocking dcb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire [1:0] mode = converter_word[13:12];
   // ==========================================================
   // word and converter outputs
   a_top_bits_zero: assert property (converter_word[15:14] == 2'h0)
      else $error("upper word bits not zero");
   a_code_map: assert property ($stable(converter_word) [*3] |->
      conv.code == converter_word[11:2]) else $error("converter code not word bits 11:2");
   a_pd_flag: assert property ($stable(converter_word) [*3] |->
      conv.powered_down == (mode != 2'h0)) else $error("power-down flag wrong");
   a_term_select: assert property ($stable(converter_word) [*3] |->
      {conv.term_2k5, conv.term_100k, conv.term_hiz} == {mode == 2'h1, mode == 2'h2, mode == 2'h3})
      else $error("termination select wrong");
   // word may only move while scl is high in the ack bit
   a_word_at_ack: assert property ($changed(converter_word) |-> scl_in && $past(scl_in, 2))
      else $error("word changed outside ack high phase");
   // ==========================================================
   // bus behaviour
   a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in && !sda_out)
      else $error("sda pulled while scl high");
   a_hs_no_ack: assert property ($rose(hs_mode) |-> ##6 !sda_oe [*8])
      else $error("master code acknowledged");
   a_hs_until_stop: assert property ($fell(hs_mode) |-> scl_in && sda_in)
      else $error("high speed left without stop");
   c_word: cover property ($changed(converter_word));
   c_hs: cover property ($rose(hs_mode));
   c_ack: cover property ($rose(sda_oe));
endmodule

bind idw_slave idw_slave_checker u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .two_pin_variant(two_pin_variant), .addr_select_high_pin(addr_select_high_pin),
   .addr_select_low_pin(addr_select_low_pin), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .conv(conv), .converter_word(converter_word),
   .hs_mode(hs_mode));

/* test/tb.sv */
// self-checking bench for idw_slave driven by the behavioural master.
// assumes: bus idle high during reset; sda has a pull-up.
`timescale 1ns/1ns
module tb;
   import idw_pkg::*;
   logic clk_sys, sys_rst, two_pin_variant, sda_out, sda_oe, hs_mode, scl, m_low, a;
   logic [15:0] w, exp_w, rd, converter_word;
   idw_level_t lvl_h, lvl_l;
   idw_conv_t conv;
   int mismatches, checks_done, c;
   wire sda = !((sda_oe && !sda_out) || m_low);
   idw_slave uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .two_pin_variant(two_pin_variant),
      .addr_select_high_pin(lvl_h), .addr_select_low_pin(lvl_l), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .conv(conv),
      .converter_word(converter_word), .hs_mode(hs_mode));
   idw_bus_master mst (.scl(scl), .sda_low(m_low), .sda(sda));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ==========================================================
   // expectations and checks
   function automatic logic [6:0] exp_addr(logic v, int h, int l);
      if (!v) return IDW_ADDR_SINGLE_FLOAT + 7'(l);
      return (h == 0 ? IDW_BASE_HIGH_FLOAT : h == 1 ? IDW_BASE_HIGH_GND
         : IDW_BASE_HIGH_SUPPLY) + 7'(l);
   endfunction
   function automatic idw_conv_t exp_conv(logic [15:0] x);
      logic [1:0] m = x[13:12];
      return '{x[11:2], m != 2'h0, m == IDW_MODE_PD_2K5, m == IDW_MODE_PD_100K,
         m == IDW_MODE_PD_HIZ};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      if (mismatches == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // frame helpers
   task automatic do_reset();
      sys_rst = 1'b1;
      repeat (20) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   task automatic send_addr(input logic [7:0] ab, input logic exp_ack);
      logic k;
      mst.start_cond();
      mst.wr_byte(ab, k);
      chk(k, exp_ack);
   endtask
   task automatic put_word(input logic [15:0] x);
      logic a0, a1;
      mst.wr_byte(x[15:8], a0);
      mst.wr_byte(x[7:0], a1);
      exp_w = {2'b00, x[13:0]};
      chk({a0, a1}, 2'b11);
      chk(converter_word, exp_w);
      chk(conv, exp_conv(exp_w));
   endtask
   initial begin
      #500000;
      mismatches++;
      report_and_stop();
   end
   // ==========================================================
   // main sequence
   initial begin
      mismatches = 0;
      checks_done = 0;
      c = $urandom(13595);
      two_pin_variant = 1'b0;
      lvl_h = IDW_LVL_FLOAT;
      lvl_l = IDW_LVL_GND;
      do_reset();
      chk({conv, converter_word}, 30'h0);
      send_addr({IDW_ADDR_SINGLE_SUPPLY, 1'b0}, 1'b0);
      mst.stop_cond();
      send_addr({IDW_ADDR_SINGLE_GND, 1'b0}, 1'b1);
      // every mode back to back, all-ones corner last
      for (int m = 0; m < 5; m++) begin
         w = (m == 4) ? 16'hFFFF : {2'(m ^ 1), 2'(m), 12'($urandom())};
         put_word(w);
      end
      mst.stop_cond();
      send_addr({IDW_ADDR_SINGLE_GND, 1'b1}, 1'b1);
      mst.rd_byte(rd[15:8], 1'b1);
      mst.rd_byte(rd[7:0], 1'b0);
      mst.stop_cond();
      chk(rd, exp_w);
      lvl_l = IDW_LVL_SUPPLY;
      send_addr({IDW_ADDR_SINGLE_GND, 1'b0}, 1'b1);
      put_word(16'($urandom()) & 16'hCFFF);
      mst.stop_cond();
      send_addr({IDW_ADDR_SINGLE_SUPPLY, 1'b0}, 1'b0);
      mst.stop_cond();
      send_addr({IDW_ADDR_BROADCAST, 1'b0}, 1'b1);
      put_word(16'($urandom()) | 16'h1000);
      mst.stop_cond();
      mst.start_cond();
      mst.wr_byte({IDW_MASTER_CODE_TOP, 3'($urandom())}, a);
      chk({a, hs_mode}, 2'b01);
      send_addr({IDW_ADDR_SINGLE_GND, 1'b0}, 1'b1);
      put_word(16'($urandom()));
      chk(hs_mode, 1'b1);
      mst.stop_cond();
      send_addr({IDW_ADDR_SINGLE_GND, 1'b0}, 1'b1);
      mst.stop_cond();
      chk(hs_mode, 1'b0);
      // each strap setting needs a fresh reset, since the address locks
      for (int v = 0; v < 2; v++)
         for (int h = 0; h < 3; h++)
            for (int l = 0; l < 3; l++) begin
               two_pin_variant = v[0];
               lvl_h = idw_level_t'(h);
               lvl_l = idw_level_t'(l);
               do_reset();
               send_addr({exp_addr(v[0], h, l) ^ 7'h20, 1'b0}, 1'b0);
               mst.stop_cond();
               send_addr({exp_addr(v[0], h, l), 1'b0}, 1'b1);
               mst.stop_cond();
            end
      report_and_stop();
   end
endmodule
